// >>> logic/opks_pkg.sv
// Package for the operator panel key status block.
// Assumes one hclk domain; shared by the top module and its two leaves.
package opks_pkg;
    // ----------------------------------------
    // Panel count and key widths
    // ----------------------------------------
    localparam int OPKS_NUM_PANELS = 8;
    localparam int OPKS_IDX_W = 3;
    localparam int OPKS_CNT_W = 4;
    localparam int OPKS_USER_W = 16;
    localparam int OPKS_JOG_W = 15;
    localparam int OPKS_SPDL_W = 6;
    localparam int OPKS_FEED_W = 5;
    localparam int OPKS_MOVE_W = 4;
    localparam int OPKS_KIND_W = 2;

    // ----------------------------------------
    // Field positions in the two key-map words
    // ----------------------------------------
    localparam int OPKS_USER_LO = 0;
    localparam int OPKS_JOG_LO = 16;
    localparam int OPKS_SPDL_LO = 0;
    localparam int OPKS_START_BIT = 6;
    localparam int OPKS_STOP_BIT = 7;
    localparam int OPKS_ZERO_BIT = 11;
    localparam int OPKS_SBLK_BIT = 13;
    localparam int OPKS_RESET_BIT = 15;
    localparam int OPKS_FEED_LO = 16;
    localparam int OPKS_MOVE_LO = 24;
    localparam logic [31:0] OPKS_WORD_A_USED = 32'h7FFF_FFFF;
    localparam logic [31:0] OPKS_WORD_B_USED = 32'h0F1F_A8FF;

    // Selector codes: 22 is 200 % feed, 8 is continuous jog
    localparam logic [4:0] OPKS_FEED_CODE_MAX = 5'h16;
    localparam logic [3:0] OPKS_MOVE_CODE_MAX = 4'h8;

    // ----------------------------------------
    // Panel kinds and their populated keys
    // ----------------------------------------
    typedef enum logic [1:0] {
        OPKS_KIND_LARGE,
        OPKS_KIND_COMPACT,
        OPKS_KIND_JOG,
        OPKS_KIND_NONE
    } opks_kind_type;

    localparam logic [15:0] OPKS_USER_MASK_LARGE = 16'hFFFF;
    localparam logic [15:0] OPKS_USER_MASK_COMPACT = 16'h003F;
    localparam logic [15:0] OPKS_USER_MASK_JOG = 16'h3FFF;
    localparam logic [14:0] OPKS_JOG_MASK_LARGE = 15'h7FFF;
    localparam logic [14:0] OPKS_JOG_MASK_COMPACT = 15'h01FF;
    localparam logic [14:0] OPKS_JOG_MASK_JOG = 15'h0FFF;

    function automatic logic [15:0] opks_user_mask(input opks_kind_type k);
        case (k)
            OPKS_KIND_LARGE: opks_user_mask = OPKS_USER_MASK_LARGE;
            OPKS_KIND_COMPACT: opks_user_mask = OPKS_USER_MASK_COMPACT;
            OPKS_KIND_JOG: opks_user_mask = OPKS_USER_MASK_JOG;
            default: opks_user_mask = 16'h0000;
        endcase
    endfunction

    function automatic logic [14:0] opks_jog_mask(input opks_kind_type k);
        case (k)
            OPKS_KIND_LARGE: opks_jog_mask = OPKS_JOG_MASK_LARGE;
            OPKS_KIND_COMPACT: opks_jog_mask = OPKS_JOG_MASK_COMPACT;
            OPKS_KIND_JOG: opks_jog_mask = OPKS_JOG_MASK_JOG;
            default: opks_jog_mask = 15'h0000;
        endcase
    endfunction

    // ----------------------------------------
    // Register map (byte addresses, low 8 bits decoded)
    // ----------------------------------------
    localparam logic [7:0] OPKS_ADDR_GEN_A = 8'h00;
    localparam logic [7:0] OPKS_ADDR_GEN_B = 8'h04;
    localparam logic [7:0] OPKS_ADDR_STATUS = 8'h08;
    localparam logic [7:0] OPKS_ADDR_CTRL = 8'h0C;
    localparam logic [7:0] OPKS_ADDR_PANEL_BASE = 8'h10;
    localparam logic [7:0] OPKS_ADDR_PANEL_END = 8'h50;
    localparam int OPKS_PANEL_SHIFT = 3;
    localparam int OPKS_WORD_B_ADDR_BIT = 2;

    localparam int OPKS_STAT_SEL_LO = 0;
    localparam int OPKS_STAT_CNT_LO = 8;
    localparam int OPKS_STAT_PRES_LO = 16;
    localparam int OPKS_CTRL_REFRESH_BIT = 0;
    localparam logic [31:0] OPKS_CTRL_MASK = 32'h0000_0001;
    localparam logic [31:0] OPKS_CTRL_RESET = 32'h0000_0001;

    // AHB-Lite encodings
    localparam logic [1:0] OPKS_HTRANS_NONSEQ = 2'h2;
    localparam logic OPKS_HRESP_OKAY = 1'b0;
endpackage

// >>> logic/opks_panel_fmt.sv
// Packs one panel's raw key, switch and selector levels into its two words.
// Assumes the raw levels are synchronous to the clock; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module opks_panel_fmt
    import opks_pkg::*;
(
    input wire logic present,
    input wire logic [OPKS_KIND_W-1:0] kind,
    input wire logic [OPKS_USER_W-1:0] user_keys,
    input wire logic [OPKS_JOG_W-1:0] jog_keys,
    input wire logic [OPKS_SPDL_W-1:0] spindle_keys,
    input wire logic start_key,
    input wire logic stop_key,
    input wire logic zero_sel,
    input wire logic sblock_sel,
    input wire logic reset_key,
    input wire logic [OPKS_FEED_W-1:0] feed_ovr,
    input wire logic [OPKS_MOVE_W-1:0] move_sel,
    output logic [31:0] word_a,
    output logic [31:0] word_b
);
    wire opks_kind_type kind_e = opks_kind_type'(kind);
    // Out-of-range selector codes saturate so software never sees a gap code
    wire logic [OPKS_FEED_W-1:0] feed_clip =
        (feed_ovr > OPKS_FEED_CODE_MAX) ? OPKS_FEED_CODE_MAX : feed_ovr;
    wire logic [OPKS_MOVE_W-1:0] move_clip =
        (move_sel > OPKS_MOVE_CODE_MAX) ? OPKS_MOVE_CODE_MAX : move_sel;
    wire logic [OPKS_USER_W-1:0] user_m = user_keys & opks_user_mask(kind_e);
    wire logic [OPKS_JOG_W-1:0] jog_m = jog_keys & opks_jog_mask(kind_e);

    always_comb begin
        word_a = 32'h0000_0000;
        word_b = 32'h0000_0000;
        if (present) begin
            word_a[OPKS_USER_LO +: OPKS_USER_W] = user_m;
            word_a[OPKS_JOG_LO +: OPKS_JOG_W] = jog_m;
            word_b[OPKS_SPDL_LO +: OPKS_SPDL_W] = spindle_keys;
            word_b[OPKS_START_BIT] = start_key;
            word_b[OPKS_STOP_BIT] = stop_key;
            word_b[OPKS_ZERO_BIT] = zero_sel;
            word_b[OPKS_SBLK_BIT] = sblock_sel;
            word_b[OPKS_RESET_BIT] = reset_key;
            word_b[OPKS_FEED_LO +: OPKS_FEED_W] = feed_clip;
            word_b[OPKS_MOVE_LO +: OPKS_MOVE_W] = move_clip;
        end
    end
endmodule
`default_nettype wire

// >>> logic/opks_last_used.sv
// Tracks which panel was used last: the lowest-numbered panel with a new press.
// Assumes refresh is a one-cycle strobe and prev words are the held words.
`timescale 1ns/100ps
`default_nettype none
module opks_last_used
    import opks_pkg::*;
#(
    parameter int N_PANELS = OPKS_NUM_PANELS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic refresh,
    input wire logic [N_PANELS-1:0] present,
    input wire logic [N_PANELS*64-1:0] cur_words,
    input wire logic [N_PANELS*64-1:0] prev_words,
    output logic [OPKS_IDX_W-1:0] sel,
    output logic [OPKS_CNT_W-1:0] present_cnt
);
    logic [OPKS_IDX_W-1:0] sel_r;
    logic [OPKS_IDX_W-1:0] sel_nxt;
    logic [N_PANELS-1:0] pressed;

    genvar g;
    generate
        for (g = 0; g < N_PANELS; g++) begin : g_press
            assign pressed[g] = |(cur_words[g*64 +: 64] & ~prev_words[g*64 +: 64]);
        end
    endgenerate

    always_comb begin
        present_cnt = '0;
        sel_nxt = sel_r;
        for (int i = N_PANELS - 1; i >= 0; i--) begin
            present_cnt = present_cnt + OPKS_CNT_W'(present[i]);
            if (pressed[i]) begin
                sel_nxt = OPKS_IDX_W'(i);
            end
        end
        // A lone keyboard is always the first panel
        if (present_cnt <= OPKS_CNT_W'(1)) begin
            sel_nxt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= '0;
        end else if (refresh) begin
            sel_r <= sel_nxt;
        end
    end

    assign sel = sel_r;
endmodule
`default_nettype wire

// >>> logic/opks_key_status.sv
// Operator panel key status bank with an AHB-Lite register slave.
// Assumes panel levels synchronous to hclk and a one-cycle scan_tick strobe.
`timescale 1ns/100ps
`default_nettype none
module opks_key_status
    import opks_pkg::*;
#(
    parameter int N_PANELS = OPKS_NUM_PANELS
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic scan_tick,
    input wire logic [N_PANELS-1:0] panel_present,
    input wire logic [N_PANELS*OPKS_KIND_W-1:0] panel_kind,
    input wire logic [N_PANELS*OPKS_USER_W-1:0] panel_user_keys,
    input wire logic [N_PANELS*OPKS_JOG_W-1:0] panel_jog_keys,
    input wire logic [N_PANELS*OPKS_SPDL_W-1:0] panel_spindle_keys,
    input wire logic [N_PANELS-1:0] panel_start_key,
    input wire logic [N_PANELS-1:0] panel_stop_key,
    input wire logic [N_PANELS-1:0] panel_zero_sel,
    input wire logic [N_PANELS-1:0] panel_sblock_sel,
    input wire logic [N_PANELS-1:0] panel_reset_key,
    input wire logic [N_PANELS*OPKS_FEED_W-1:0] panel_feed_ovr,
    input wire logic [N_PANELS*OPKS_MOVE_W-1:0] panel_move_sel
);
    // ----------------------------------------
    // Panel formatting and held words
    // ----------------------------------------
    logic [31:0] fmt_a [N_PANELS];
    logic [31:0] fmt_b [N_PANELS];
    logic [31:0] pan_a_r [N_PANELS];
    logic [31:0] pan_b_r [N_PANELS];
    logic [N_PANELS*64-1:0] cur_flat;
    logic [N_PANELS*64-1:0] prev_flat;
    logic [31:0] ctrl_r;
    logic [31:0] gen_a_r;
    logic [31:0] gen_b_r;
    logic [OPKS_IDX_W-1:0] sel;
    logic [OPKS_CNT_W-1:0] present_cnt;

    // Software may freeze the snapshot so a multi-word read stays coherent
    wire logic refresh = scan_tick & ctrl_r[OPKS_CTRL_REFRESH_BIT];

    genvar g;
    generate
        for (g = 0; g < N_PANELS; g++) begin : g_panel
            opks_panel_fmt u_fmt (
                .present(panel_present[g]),
                .kind(panel_kind[g*OPKS_KIND_W +: OPKS_KIND_W]),
                .user_keys(panel_user_keys[g*OPKS_USER_W +: OPKS_USER_W]),
                .jog_keys(panel_jog_keys[g*OPKS_JOG_W +: OPKS_JOG_W]),
                .spindle_keys(panel_spindle_keys[g*OPKS_SPDL_W +: OPKS_SPDL_W]),
                .start_key(panel_start_key[g]),
                .stop_key(panel_stop_key[g]),
                .zero_sel(panel_zero_sel[g]),
                .sblock_sel(panel_sblock_sel[g]),
                .reset_key(panel_reset_key[g]),
                .feed_ovr(panel_feed_ovr[g*OPKS_FEED_W +: OPKS_FEED_W]),
                .move_sel(panel_move_sel[g*OPKS_MOVE_W +: OPKS_MOVE_W]),
                .word_a(fmt_a[g]),
                .word_b(fmt_b[g])
            );
            assign cur_flat[g*64 +: 64] = {fmt_b[g], fmt_a[g]};
            assign prev_flat[g*64 +: 64] = {pan_b_r[g], pan_a_r[g]};

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pan_a_r[g] <= 32'h0000_0000;
                    pan_b_r[g] <= 32'h0000_0000;
                end else if (refresh) begin
                    pan_a_r[g] <= fmt_a[g] & OPKS_WORD_A_USED;
                    pan_b_r[g] <= fmt_b[g] & OPKS_WORD_B_USED;
                end
            end
        end
    endgenerate

    opks_last_used #(
        .N_PANELS(N_PANELS)
    ) u_last (
        .hclk(hclk),
        .hresetn(hresetn),
        .refresh(refresh),
        .present(panel_present),
        .cur_words(cur_flat),
        .prev_words(prev_flat),
        .sel(sel),
        .present_cnt(present_cnt)
    );

    // General words trail the panel words by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_a_r <= 32'h0000_0000;
            gen_b_r <= 32'h0000_0000;
        end else begin
            gen_a_r <= pan_a_r[sel];
            gen_b_r <= pan_b_r[sel];
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    function automatic logic opks_is_panel(input logic [7:0] a);
        opks_is_panel = (a >= OPKS_ADDR_PANEL_BASE) && (a < OPKS_ADDR_PANEL_END);
    endfunction

    function automatic logic [OPKS_IDX_W-1:0] opks_panel_idx(input logic [7:0] a);
        logic [7:0] off;
        off = a - OPKS_ADDR_PANEL_BASE;
        opks_panel_idx = OPKS_IDX_W'(off >> OPKS_PANEL_SHIFT);
    endfunction

    wire logic [7:0] addr_lo = haddr[7:0];
    wire logic xfer = hsel & hready & htrans[1];
    wire logic rd_take = xfer & ~hwrite;
    wire logic wr_take = xfer & hwrite;
    wire logic [OPKS_IDX_W-1:0] rd_idx = opks_panel_idx(addr_lo);
    wire logic rd_word_b = addr_lo[OPKS_WORD_B_ADDR_BIT];
    wire logic [31:0] status_word = {8'h00, 8'(panel_present),
        4'h0, present_cnt, 5'h00, sel};
    wire logic [31:0] panel_word = rd_word_b ? pan_b_r[rd_idx] : pan_a_r[rd_idx];
    wire logic [31:0] rd_data_nxt =
        (addr_lo == OPKS_ADDR_GEN_A) ? gen_a_r :
        (addr_lo == OPKS_ADDR_GEN_B) ? gen_b_r :
        (addr_lo == OPKS_ADDR_STATUS) ? status_word :
        (addr_lo == OPKS_ADDR_CTRL) ? ctrl_r :
        opks_is_panel(addr_lo) ? panel_word : 32'h0000_0000;

    logic wr_pend_r;
    logic [7:0] wr_addr_r;

    // Zero wait states: read data is fetched at the address-phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= OPKS_HRESP_OKAY;
        end else if (rd_take) begin
            hrdata <= rd_data_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= wr_take;
            wr_addr_r <= addr_lo;
        end
    end

    // Key words are read-only; only the control word takes writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= OPKS_CTRL_RESET;
        end else if (wr_pend_r && wr_addr_r == OPKS_ADDR_CTRL) begin
            ctrl_r <= hwdata & OPKS_CTRL_MASK;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_GEN_FOLLOWS_SEL: assert property (
        ##1 (gen_a_r == $past(pan_a_r[sel])) && (gen_b_r == $past(pan_b_r[sel])))
        else $error("general words do not follow the last-used panel");

    AST_LONE_PANEL_FIRST: assert property (
        (refresh && present_cnt <= 4'h1) |=> (sel == 3'h0) ##2 (gen_a_r == pan_a_r[0]))
        else $error("single keyboard not mirrored from panel one");

    AST_PANEL_CAPTURE: assert property (
        refresh |=> (pan_a_r[N_PANELS-1] == $past(fmt_a[N_PANELS-1] & OPKS_WORD_A_USED)))
        else $error("last panel word a not captured on refresh");

    AST_COMPACT_USER_ZERO: assert property (
        (refresh && panel_present[1] && panel_kind[3:2] == 2'h1)
        |=> (pan_a_r[1][15:6] == 10'h000) && (pan_a_r[1][30:25] == 6'h00))
        else $error("compact panel reports a missing user key");

    AST_JOG_KEY_POS: assert property (
        (refresh && panel_present[0] && panel_kind[1:0] == 2'h0)
        |=> (pan_a_r[0][30:16] == $past(panel_jog_keys[14:0])) && !pan_a_r[0][31])
        else $error("jog keys not at bits 16 to 30");

    AST_START_STOP_POS: assert property (
        (refresh && panel_present[0]) |=> (pan_b_r[0][7:6] ==
        {$past(panel_stop_key[0]), $past(panel_start_key[0])}))
        else $error("start or stop key misplaced");

    AST_RESET_SEL_POS: assert property (
        (refresh && panel_present[0]) |=>
        (pan_b_r[0][15] == $past(panel_reset_key[0])) &&
        (pan_b_r[0][13] == $past(panel_sblock_sel[0])) &&
        (pan_b_r[0][11] == $past(panel_zero_sel[0])))
        else $error("selector bit misplaced");

    AST_FEED_RANGE: assert property (
        (refresh && panel_present[0] && panel_feed_ovr[4:0] <= 5'h16)
        |=> (pan_b_r[0][20:16] == $past(panel_feed_ovr[4:0])))
        else $error("feed override code altered");

    AST_MOVE_RANGE: assert property (
        (pan_b_r[0][27:24] <= 4'h8) && (gen_b_r[27:24] <= 4'h8))
        else $error("movement code above continuous jog");

    AST_UNUSED_ZERO: assert property (
        ((gen_b_r & ~OPKS_WORD_B_USED) == 32'h0000_0000) && !gen_a_r[31])
        else $error("unassigned bit reads one");

    AST_HOLD_NO_TICK: assert property (
        !refresh |=> $stable(pan_b_r[0]) && $stable(pan_a_r[0]))
        else $error("panel word changed without a scan");

    AST_READ_ONE_CYCLE: assert property (
        rd_take |=> hreadyout && hresp == OPKS_HRESP_OKAY)
        else $error("read not answered in the next cycle");

    COV_REFRESH: cover property (refresh ##1 pan_a_r[0] != 32'h0000_0000);
    COV_SEL_MOVE: cover property (refresh ##1 sel != 3'h0);
    COV_FROZEN: cover property (scan_tick && !ctrl_r[OPKS_CTRL_REFRESH_BIT]);
    COV_CTRL_WRITE: cover property (wr_take && addr_lo == OPKS_ADDR_CTRL);
endmodule
`default_nettype wire

// >>> dv/opks_panel_model.sv
// Behavioural model of up to eight operator and jog panels at the far side.
// Assumes the bench sets each panel through set_panel right after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module opks_panel_model
    import opks_pkg::*;
(
    input wire logic hclk,
    output logic [OPKS_NUM_PANELS-1:0] panel_present,
    output logic [OPKS_NUM_PANELS*OPKS_KIND_W-1:0] panel_kind,
    output logic [OPKS_NUM_PANELS*OPKS_USER_W-1:0] panel_user_keys,
    output logic [OPKS_NUM_PANELS*OPKS_JOG_W-1:0] panel_jog_keys,
    output logic [OPKS_NUM_PANELS*OPKS_SPDL_W-1:0] panel_spindle_keys,
    output logic [OPKS_NUM_PANELS-1:0] panel_start_key,
    output logic [OPKS_NUM_PANELS-1:0] panel_stop_key,
    output logic [OPKS_NUM_PANELS-1:0] panel_zero_sel,
    output logic [OPKS_NUM_PANELS-1:0] panel_sblock_sel,
    output logic [OPKS_NUM_PANELS-1:0] panel_reset_key,
    output logic [OPKS_NUM_PANELS*OPKS_FEED_W-1:0] panel_feed_ovr,
    output logic [OPKS_NUM_PANELS*OPKS_MOVE_W-1:0] panel_move_sel
);
    logic [OPKS_NUM_PANELS-1:0] pres_r;
    logic [1:0] kind_r [OPKS_NUM_PANELS];
    logic [30:0] a_r [OPKS_NUM_PANELS];
    logic [31:0] b_r [OPKS_NUM_PANELS];
    logic [15:0] noise_r;

    initial begin
        pres_r = 8'h00;
        noise_r = 16'h5A3C;
        for (int i = 0; i < OPKS_NUM_PANELS; i++) begin
            kind_r[i] = 2'h0;
            a_r[i] = 31'h0000_0000;
            b_r[i] = 32'h0000_0000;
        end
    end

    // Unplugged panel lines float: a changing pattern, never the last value
    always @(posedge hclk) begin
        noise_r <= noise_r + 16'h9E37;
    end

    always_comb begin
        logic [30:0] ga;
        logic [31:0] gb;
        ga = 31'h0000_0000;
        gb = 32'h0000_0000;
        panel_present = pres_r;
        for (int i = 0; i < OPKS_NUM_PANELS; i++) begin
            ga = pres_r[i] ? a_r[i] : {noise_r[14:0], ~noise_r};
            gb = pres_r[i] ? b_r[i] : {~noise_r, noise_r};
            panel_kind[2*i +: 2] = kind_r[i];
            panel_user_keys[16*i +: 16] = ga[15:0];
            panel_jog_keys[15*i +: 15] = ga[30:16];
            panel_spindle_keys[6*i +: 6] = gb[5:0];
            panel_start_key[i] = gb[6];
            panel_stop_key[i] = gb[7];
            panel_zero_sel[i] = gb[11];
            panel_sblock_sel[i] = gb[13];
            panel_reset_key[i] = gb[15];
            panel_feed_ovr[5*i +: 5] = gb[20:16];
            panel_move_sel[4*i +: 4] = gb[27:24];
        end
    end

    // Raw levels laid out as in the two key-map words
    task automatic set_panel(input int i, input logic p, input logic [1:0] k,
                             input logic [30:0] a, input logic [31:0] b);
        pres_r[i] <= p;
        kind_r[i] <= k;
        a_r[i] <= a;
        b_r[i] <= b;
    endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench: AHB-Lite reads and writes against a panel model.
// Assumes zero-wait-state slave and a refresh on each scan_tick when enabled.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import opks_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic scan_tick = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [7:0] p_pres, p_start, p_stop, p_zero, p_sblk, p_rst;
    wire logic [15:0] p_kind;
    wire logic [127:0] p_user;
    wire logic [119:0] p_jog;
    wire logic [47:0] p_spdl;
    wire logic [39:0] p_feed;
    wire logic [31:0] p_move;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [7:0] epres = 8'h00;
    logic [1:0] ek [8];
    logic [30:0] ra [8];
    logic [31:0] rb [8];
    logic [31:0] ew_a [8];
    logic [31:0] ew_b [8];
    logic [2:0] esel = 3'h0;
    logic ctrl_en = 1'b1;

    always #5 hclk = ~hclk;

    opks_key_status dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .scan_tick(scan_tick), .panel_present(p_pres), .panel_kind(p_kind),
        .panel_user_keys(p_user), .panel_jog_keys(p_jog), .panel_spindle_keys(p_spdl),
        .panel_start_key(p_start), .panel_stop_key(p_stop), .panel_zero_sel(p_zero),
        .panel_sblock_sel(p_sblk), .panel_reset_key(p_rst), .panel_feed_ovr(p_feed),
        .panel_move_sel(p_move));

    opks_panel_model pm_u (.hclk(hclk), .panel_present(p_pres), .panel_kind(p_kind),
        .panel_user_keys(p_user), .panel_jog_keys(p_jog), .panel_spindle_keys(p_spdl),
        .panel_start_key(p_start), .panel_stop_key(p_stop), .panel_zero_sel(p_zero),
        .panel_sblock_sel(p_sblk), .panel_reset_key(p_rst), .panel_feed_ovr(p_feed),
        .panel_move_sel(p_move));

    // ----------------------------------------
    // Expected word formatting
    // ----------------------------------------
    function automatic logic [31:0] fmt_a(input logic [1:0] k, input logic [30:0] a);
        case (k)
            2'h0: fmt_a = {1'b0, a & {OPKS_JOG_MASK_LARGE, OPKS_USER_MASK_LARGE}};
            2'h1: fmt_a = {1'b0, a & {OPKS_JOG_MASK_COMPACT, OPKS_USER_MASK_COMPACT}};
            2'h2: fmt_a = {1'b0, a & {OPKS_JOG_MASK_JOG, OPKS_USER_MASK_JOG}};
            default: fmt_a = 32'h0000_0000;
        endcase
    endfunction

    function automatic logic [31:0] fmt_b(input logic [31:0] b);
        logic [31:0] r;
        r = b & OPKS_WORD_B_USED;
        if (r[20:16] > 5'h16) r[20:16] = 5'h16;
        if (r[27:24] > 4'h8) r[27:24] = 4'h8;
        fmt_b = r;
    endfunction

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= OPKS_HTRANS_NONSEQ;
        hwrite <= 1'b0;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        rdy();
        d = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= OPKS_HTRANS_NONSEQ;
        hwrite <= 1'b1;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d, exp);
        chk("hresp", {31'h0, hresp}, {31'h0, OPKS_HRESP_OKAY});
    endtask

    task automatic setp(input int i, input logic p, input logic [1:0] k,
                        input logic [30:0] a, input logic [31:0] b);
        epres[i] = p;
        ek[i] = k;
        ra[i] = a;
        rb[i] = b;
        pm_u.set_panel(i, p, k, a, b);
    endtask

    // Reference last-used tracking: lowest panel whose words gained a set bit
    task automatic scan;
        logic [31:0] na, nb;
        int best;
        @(posedge hclk);
        scan_tick <= 1'b1;
        @(posedge hclk);
        scan_tick <= 1'b0;
        if (ctrl_en) begin
            best = -1;
            for (int i = 0; i < 8; i++) begin
                na = epres[i] ? fmt_a(ek[i], ra[i]) : 32'h0000_0000;
                nb = epres[i] ? fmt_b(rb[i]) : 32'h0000_0000;
                if (best < 0 && ((na & ~ew_a[i]) != 0 || (nb & ~ew_b[i]) != 0)) best = i;
                ew_a[i] = na;
                ew_b[i] = nb;
            end
            if ($countones(epres) <= 1) esel = 3'h0;
            else if (best >= 0) esel = best[2:0];
        end
        @(posedge hclk);
    endtask

    task automatic verify;
        logic [3:0] cnt;
        cnt = 4'($countones(epres));
        rdc("general_a", OPKS_ADDR_GEN_A, ew_a[esel]);
        rdc("general_b", OPKS_ADDR_GEN_B, ew_b[esel]);
        rdc("status", OPKS_ADDR_STATUS, {8'h00, epres, 4'h0, cnt, 5'h00, esel});
        for (int i = 0; i < 8; i++) begin
            rdc("panel_a", OPKS_ADDR_PANEL_BASE + 8'(8 * i), ew_a[i]);
            rdc("panel_b", OPKS_ADDR_PANEL_BASE + 8'(8 * i + 4), ew_b[i]);
        end
    endtask

    task automatic wrap_up;
        $display("checks_done %0d n_errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and still reaches the closing report
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        int c;
        for (int i = 0; i < 8; i++) begin
            ek[i] = 2'h0;
            ra[i] = 31'h0000_0000;
            rb[i] = 32'h0000_0000;
            ew_a[i] = 32'h0000_0000;
            ew_b[i] = 32'h0000_0000;
        end
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        verify();
        rdc("ctrl", OPKS_ADDR_CTRL, OPKS_CTRL_RESET);
        rdc("unmapped", OPKS_ADDR_PANEL_END, 32'h0000_0000);
        rdc("unmapped", 8'hFC, 32'h0000_0000);
        $display("test reset done");

        setp(0, 1'b1, 2'h0, 31'h7FFF_FFFF, 32'hFFFF_FFFF);
        scan();
        verify();
        $display("test single panel done");

        setp(1, 1'b1, 2'h1, 31'h7FFF_FFFF, 32'h0815_A8C1);
        setp(2, 1'b1, 2'h2, 31'h7FFF_FFFF, 32'h0300_0012);
        setp(3, 1'b1, 2'h3, 31'h7FFF_FFFF, 32'h0000_0000);
        scan();
        verify();
        setp(1, 1'b1, 2'h1, 31'h0000_0000, 32'h0000_0000);
        setp(2, 1'b1, 2'h2, 31'h0001_0001, 32'h0300_0012);
        setp(4, 1'b1, 2'h0, 31'h4000_8000, 32'h0000_2800);
        scan();
        verify();
        $display("test panel kinds and last used done");

        for (c = 0; c <= 22; c++) begin
            setp(6, 1'b1, 2'h0, 31'h0000_0000, {4'h0, 4'(c % 9), 3'h0, 5'(c), 16'h0000});
            scan();
            rdc("feed_move", OPKS_ADDR_PANEL_BASE + 8'h34, ew_b[6]);
        end
        rdc("general_b", OPKS_ADDR_GEN_B, ew_b[esel]);
        $display("test selector codes done");

        wr(OPKS_ADDR_CTRL, 32'hFFFF_FFFE);
        ctrl_en = 1'b0;
        rdc("ctrl", OPKS_ADDR_CTRL, 32'h0000_0000);
        wr(OPKS_ADDR_GEN_A, 32'hFFFF_FFFF);
        wr(OPKS_ADDR_PANEL_BASE, 32'hFFFF_FFFF);
        setp(0, 1'b1, 2'h0, 31'h0000_0003, 32'h0000_0040);
        setp(5, 1'b0, 2'h0, 31'h7FFF_FFFF, 32'hFFFF_FFFF);
        scan();
        verify();
        wr(OPKS_ADDR_CTRL, 32'h0000_0001);
        ctrl_en = 1'b1;
        rdc("ctrl", OPKS_ADDR_CTRL, 32'h0000_0001);
        scan();
        verify();
        $display("test freeze and writes done");
        wrap_up();
    end
endmodule
`default_nettype wire
